//--- core/tmr_capture_compare.sv
// dual channel capture/compare timer unit with apb register access
`timescale 1ns/1ps
`default_nettype none
module tmr_capture_compare (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_resetn,
  input  wire tmr_pkg::tmr_apb_req_type  i_apb,
  output var  tmr_pkg::tmr_apb_rsp_type  o_apb,
  input  wire logic [tmr_pkg::CH_N-1:0]  i_ch_pin,
  output var  logic [tmr_pkg::CH_N-1:0]  o_ch_pin_out,
  output var  logic [tmr_pkg::CH_N-1:0]  o_ch_pin_oe_n,
  output var  logic                      o_ovf_irq,
  output var  logic [tmr_pkg::CH_N-1:0]  o_ch_irq
);
  import tmr_pkg::*;

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [PRE_W-1:0] presc_mask(input logic [2:0] ps);
    logic [PRE_W-1:0] m;
    m = 7'h7F;
    unique case (ps)
      3'h0: m = 7'h00;
      3'h1: m = 7'h01;
      3'h2: m = 7'h03;
      3'h3: m = 7'h07;
      3'h4: m = 7'h0F;
      3'h5: m = 7'h1F;
      3'h6: m = 7'h3F;
      3'h7: m = 7'h7F;
    endcase
    return m;
  endfunction : presc_mask

  function automatic tmr_mode_type chan_mode(input tmr_chan_type c);
    if (c.els == EL_NONE) begin
      return TMR_MODE_PRESET;
    end else if (c.bufsel || c.unbuf) begin
      return TMR_MODE_COMPARE;
    end
    return TMR_MODE_CAPTURE;
  endfunction : chan_mode

  function automatic logic [7:0] cs_pack(input tmr_chan_type c);
    return {c.flag, c.ie, c.bufsel, c.unbuf, c.els, c.tov, c.fmax};
  endfunction : cs_pack

  function automatic logic [8:0] read_mux(input tmr_state_type s, input logic [7:0] a);
    logic [8:0] r;
    r = 9'h000;
    case (a)
      OFS_SC:    r = {1'b1, s.ovf_flag, s.ovf_ie, s.halt, 2'b00, s.ps};
      OFS_CNTH:  r = {1'b1, s.cnt[15:8]};
      OFS_CNTL:  r = {1'b1, s.cnt_lat ? s.cnt_buf : s.cnt[7:0]};
      OFS_MODH:  r = {1'b1, s.mod[15:8]};
      OFS_MODL:  r = {1'b1, s.mod[7:0]};
      OFS_CS[0]: r = {1'b1, cs_pack(s.ch[0])};
      OFS_CS[1]: r = {1'b1, s.ch[0].bufsel ? 8'h00 : cs_pack(s.ch[1])};
      OFS_VH[0]: r = {1'b1, s.ch[0].val[15:8]};
      OFS_VL[0]: r = {1'b1, s.ch[0].val[7:0]};
      OFS_VH[1]: r = {1'b1, s.ch[1].val[15:8]};
      OFS_VL[1]: r = {1'b1, s.ch[1].val[7:0]};
      default:   r = 9'h000;
    endcase
    return r;
  endfunction : read_mux

  // ----------------------------------------------------------------------
  // state and bus decode
  // ----------------------------------------------------------------------
  tmr_state_type    st_r;
  tmr_state_type    st_nxt;
  logic [CH_N-1:0]  pin_lvl;
  logic             setup;
  logic             acc;
  logic             wr;
  logic             rds;
  logic [7:0]       wd;
  logic [8:0]       rd_res;
  logic             wr_sc;
  logic             wr_modh;
  logic             wr_modl;
  logic             rd_sc;
  logic             rd_cnth;
  logic             rd_cntl;
  logic [CH_N-1:0]  wr_cs;
  logic [CH_N-1:0]  wr_vh;
  logic [CH_N-1:0]  wr_vl;
  logic [CH_N-1:0]  rd_cs;
  logic [CH_N-1:0]  rd_vh;
  logic [CH_N-1:0]  rd_vl;

  // reads act at setup so the data and the latch see the same counter
  assign setup   = i_apb.psel & ~i_apb.penable;
  assign acc     = i_apb.psel & i_apb.penable & st_r.rsp.pready;
  assign wr      = acc & i_apb.pwrite;
  assign rds     = setup & ~i_apb.pwrite;
  assign wd      = i_apb.pwdata[7:0];
  assign rd_res  = read_mux(st_r, i_apb.paddr);
  assign wr_sc   = wr && (i_apb.paddr == OFS_SC);
  assign wr_modh = wr && (i_apb.paddr == OFS_MODH);
  assign wr_modl = wr && (i_apb.paddr == OFS_MODL);
  assign rd_sc   = rds && (i_apb.paddr == OFS_SC);
  assign rd_cnth = rds && (i_apb.paddr == OFS_CNTH);
  assign rd_cntl = rds && (i_apb.paddr == OFS_CNTL);

  // ----------------------------------------------------------------------
  // counter and channel events
  // ----------------------------------------------------------------------
  logic [PRE_W-1:0] mask;
  logic             tick;
  logic             roll;
  logic             ovf;
  logic             buffered;
  logic [CNT_W-1:0] cnt_step;
  tmr_mode_type     ch_mode [CH_N];
  logic [CNT_W-1:0] cval    [CH_N];
  logic [CH_N-1:0]  live;
  logic [CH_N-1:0]  cmp_hit;
  logic [CH_N-1:0]  cap_hit;
  logic [CH_N-1:0]  rise;
  logic [CH_N-1:0]  fall;

  assign mask     = presc_mask(st_r.ps);
  assign tick     = ~st_r.halt & (st_r.ps != PS_UNUSED) & ((st_r.pre & mask) == mask);
  assign roll     = st_r.cnt == st_r.mod;
  assign cnt_step = roll ? CNT_RESET : st_r.cnt + 16'h0001;
  assign ovf      = tick & roll;
  assign buffered = st_r.ch[0].bufsel;

  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    assign wr_cs[g]   = wr && (i_apb.paddr == OFS_CS[g]);
    assign wr_vh[g]   = wr && (i_apb.paddr == OFS_VH[g]);
    assign wr_vl[g]   = wr && (i_apb.paddr == OFS_VL[g]);
    assign rd_cs[g]   = rds && (i_apb.paddr == OFS_CS[g]);
    assign rd_vh[g]   = rds && (i_apb.paddr == OFS_VH[g]);
    assign rd_vl[g]   = rds && (i_apb.paddr == OFS_VL[g]);
    assign ch_mode[g] = chan_mode(st_r.ch[g]);
    assign live[g]    = (g == 0) || !buffered;
    assign cval[g]    = ((g == 0) && buffered) ? st_r.ch[st_r.sel].val : st_r.ch[g].val;
    assign rise[g]    = pin_lvl[g] & ~st_r.ch[g].pin_prev;
    assign fall[g]    = ~pin_lvl[g] & st_r.ch[g].pin_prev;
    assign cmp_hit[g] = tick && live[g] && (ch_mode[g] == TMR_MODE_COMPARE)
                        && !st_r.ch[g].wlock && (cnt_step == cval[g]);
    assign cap_hit[g] = live[g] && (ch_mode[g] == TMR_MODE_CAPTURE) && !st_r.halt
                        && !st_r.ch[g].rlock
                        && ((st_r.ch[g].els[0] & rise[g]) | (st_r.ch[g].els[1] & fall[g]));
  end

  tmr_pin_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_ch_pin),
    .o_level   (pin_lvl)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // zero wait state: ready in the first access cycle
    st_nxt.rsp.pready  = setup;
    st_nxt.rsp.pslverr = setup & ~rd_res[8];
    st_nxt.rsp.prdata  = rds ? {24'h000000, rd_res[7:0]} : 32'h00000000;

    if (!st_r.halt) begin
      st_nxt.pre = st_r.pre + 7'h01;
    end
    if (tick) begin
      st_nxt.cnt = cnt_step;
    end

    if (rd_sc && st_r.ovf_flag) begin
      st_nxt.ovf_arm = 1'b1;
    end
    if (wr_sc) begin
      st_nxt.ovf_ie  = wd[SC_OVFIE];
      st_nxt.halt    = wd[SC_HALT];
      st_nxt.ps      = wd[SC_PS_LO +: 3];
      st_nxt.ovf_arm = 1'b0;
      if (!wd[SC_OVF] && st_r.ovf_arm) begin
        st_nxt.ovf_flag = 1'b0;
      end
      if (wd[SC_CRST]) begin
        st_nxt.cnt     = CNT_RESET;
        st_nxt.pre     = '0;
        st_nxt.cnt_lat = 1'b0;
        st_nxt.cnt_buf = 8'h00;
      end
    end
    // a fresh overflow outranks a pending clear
    if (ovf && !st_r.mod_lock) begin
      st_nxt.ovf_flag = 1'b1;
      st_nxt.ovf_arm  = 1'b0;
    end

    if (wr_modh) begin
      st_nxt.mod[15:8] = wd;
      st_nxt.mod_lock  = 1'b1;
    end
    if (wr_modl) begin
      st_nxt.mod[7:0] = wd;
      st_nxt.mod_lock = 1'b0;
    end

    if (rd_cnth && !st_r.cnt_lat) begin
      st_nxt.cnt_buf = st_r.cnt[7:0];
      st_nxt.cnt_lat = 1'b1;
    end
    if (rd_cntl) begin
      st_nxt.cnt_lat = 1'b0;
    end

    // buffered pair: channel 0 owns the width until the other is written and the counter next overflows
    if (!buffered) begin
      st_nxt.sel     = 1'b0;
      st_nxt.last_wr = 1'b0;
    end else if (ovf) begin
      st_nxt.sel = st_r.last_wr;
    end

    for (int i = 0; i < CH_N; i++) begin
      st_nxt.ch[i].pin_prev = pin_lvl[i];
      if (rd_cs[i] && st_r.ch[i].flag) begin
        st_nxt.ch[i].arm = 1'b1;
      end
      if (wr_cs[i] && live[i]) begin
        st_nxt.ch[i].ie     = wd[CS_IE];
        st_nxt.ch[i].bufsel = (i == 0) ? wd[CS_BUF] : 1'b0;
        st_nxt.ch[i].unbuf  = wd[CS_UNBUF];
        st_nxt.ch[i].els    = wd[CS_EL_LO +: 2];
        st_nxt.ch[i].tov    = wd[CS_TOV];
        st_nxt.ch[i].fmax   = wd[CS_MAX];
        st_nxt.ch[i].arm    = 1'b0;
        if (!wd[CS_FLAG] && st_r.ch[i].arm) begin
          st_nxt.ch[i].flag = 1'b0;
        end
      end
      if (cap_hit[i]) begin
        st_nxt.ch[i].val = st_r.cnt;
      end
      if (wr_vh[i]) begin
        st_nxt.ch[i].val[15:8] = wd;
        if (ch_mode[i] == TMR_MODE_COMPARE) begin
          st_nxt.ch[i].wlock = 1'b1;
        end
      end
      if (wr_vl[i]) begin
        st_nxt.ch[i].val[7:0] = wd;
        st_nxt.ch[i].wlock    = 1'b0;
        st_nxt.last_wr        = buffered ? i[0] : 1'b0;
      end
      if (rd_vh[i] && (ch_mode[i] == TMR_MODE_CAPTURE)) begin
        st_nxt.ch[i].rlock = 1'b1;
      end
      if (rd_vl[i]) begin
        st_nxt.ch[i].rlock = 1'b0;
      end
      if (cmp_hit[i] || cap_hit[i]) begin
        st_nxt.ch[i].flag = 1'b1;
        st_nxt.ch[i].arm  = 1'b0;
      end

      // output level
      if (ch_mode[i] == TMR_MODE_PRESET) begin
        st_nxt.ch[i].lvl_out = ~st_r.ch[i].unbuf;
      end else if (ch_mode[i] == TMR_MODE_COMPARE) begin
        if (ovf && st_r.ch[i].tov) begin
          st_nxt.ch[i].max_act = st_r.ch[i].fmax;
          st_nxt.ch[i].lvl_out = (st_r.ch[i].fmax && st_r.ch[i].els == EL_LOW)
                                 ? 1'b1 : ~st_r.ch[i].lvl_out;
        end else if (cmp_hit[i] && !(st_r.ch[i].max_act && st_r.ch[i].tov
                                     && st_r.ch[i].els == EL_LOW)) begin
          unique case (st_r.ch[i].els)
            EL_NONE:   st_nxt.ch[i].lvl_out = st_r.ch[i].lvl_out;
            EL_TOGGLE: st_nxt.ch[i].lvl_out = ~st_r.ch[i].lvl_out;
            EL_LOW:    st_nxt.ch[i].lvl_out = 1'b0;
            EL_HIGH:   st_nxt.ch[i].lvl_out = 1'b1;
          endcase
        end
      end
      // capture and preset leave the pin to the port
      st_nxt.pin_out[i]  = st_nxt.ch[i].lvl_out;
      st_nxt.pin_oe_n[i] = !(live[i] && ch_mode[i] == TMR_MODE_COMPARE);
      st_nxt.ch_irq[i]   = live[i] & st_nxt.ch[i].flag & st_nxt.ch[i].ie;
    end
    st_nxt.ovf_irq = st_nxt.ovf_flag & st_nxt.ovf_ie;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_apb         = st_r.rsp;
  assign o_ch_pin_out  = st_r.pin_out;
  assign o_ch_pin_oe_n = st_r.pin_oe_n;
  assign o_ovf_irq     = st_r.ovf_irq;
  assign o_ch_irq      = st_r.ch_irq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  property p_wrap;
    ovf && !wr_sc |=> st_r.cnt == CNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not restart after modulo");

  property p_ovf_set;
    ovf && !st_r.mod_lock |=> st_r.ovf_flag ##1 o_ovf_irq == st_r.ovf_ie;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_ovf_keep;
    st_r.ovf_flag && wr_sc && (wd[SC_OVF] || !st_r.ovf_arm) |=> st_r.ovf_flag;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag cleared without arming");

  property p_ovf_irq;
    o_ovf_irq == (st_r.ovf_flag && st_r.ovf_ie);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request mismatch");

  property p_halt;
    st_r.halt && !wr_sc |=> $stable(st_r.cnt);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");

  property p_crst;
    wr_sc && wd[SC_CRST] |=> st_r.cnt == CNT_RESET && st_r.pre == 7'h00;
  endproperty
  a_crst: assert property (p_crst) else $error("counter reset bit ignored");

  property p_div1;
    st_r.ps == PS_DIV1 && !st_r.halt && !roll && !wr_sc |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided count did not step");

  property p_mod_lock;
    st_r.mod_lock && !st_r.ovf_flag |=> !st_r.ovf_flag;
  endproperty
  a_mod_lock: assert property (p_mod_lock) else $error("overflow flag set during modulo update");

  property p_cmp_flag;
    cmp_hit[0] |=> st_r.ch[0].flag ##1 o_ch_irq[0] == st_r.ch[0].ie;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("channel flag missed a match");

  property p_preset;
    st_r.ch[0].els == EL_NONE && !wr_cs[0]
      |=> o_ch_pin_oe_n[0] && o_ch_pin_out[0] == !$past(st_r.ch[0].unbuf);
  endproperty
  a_preset: assert property (p_preset) else $error("preset level or release wrong");

  property p_buf_free;
    st_r.ch[0].bufsel |=> o_ch_pin_oe_n[1] && !o_ch_irq[1];
  endproperty
  a_buf_free: assert property (p_buf_free) else $error("channel 1 still active in linked mode");

  c_ovf:  cover property (ovf && !st_r.mod_lock);
  c_cap:  cover property (cap_hit[0]);
  c_swap: cover property (buffered && ovf && st_r.last_wr);

endmodule : tmr_capture_compare
`default_nettype wire

//--- core/tmr_pin_sync.sv
// three-stage synchroniser with agreement filter for the channel pins
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_sync (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  input  wire logic [tmr_pkg::CH_N-1:0] i_pin,
  output var  logic [tmr_pkg::CH_N-1:0] o_level
);
  import tmr_pkg::*;

  tmr_sync_type st_r;
  tmr_sync_type st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // only a value held by both late stages counts
    for (int i = 0; i < CH_N; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;

endmodule : tmr_pin_sync
`default_nettype wire

//--- shared/tmr_pkg.sv
// shared constants and types for the dual channel capture/compare timer unit
package tmr_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned CH_N   = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 7;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_SC   = 8'h00;
  localparam logic [7:0] OFS_CNTH = 8'h04;
  localparam logic [7:0] OFS_CNTL = 8'h08;
  localparam logic [7:0] OFS_MODH = 8'h0C;
  localparam logic [7:0] OFS_MODL = 8'h10;
  localparam logic [1:0][7:0] OFS_CS = {8'h20, 8'h14};
  localparam logic [1:0][7:0] OFS_VH = {8'h24, 8'h18};
  localparam logic [1:0][7:0] OFS_VL = {8'h28, 8'h1C};

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned SC_OVF   = 7;
  localparam int unsigned SC_OVFIE = 6;
  localparam int unsigned SC_HALT  = 5;
  localparam int unsigned SC_CRST  = 4;
  localparam int unsigned SC_PS_LO = 0;
  localparam int unsigned CS_FLAG  = 7;
  localparam int unsigned CS_IE    = 6;
  localparam int unsigned CS_BUF   = 5;
  localparam int unsigned CS_UNBUF = 4;
  localparam int unsigned CS_EL_LO = 2;
  localparam int unsigned CS_TOV   = 1;
  localparam int unsigned CS_MAX   = 0;

  // ----------------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]       PS_DIV1   = 3'h0;
  localparam logic [2:0]       PS_UNUSED = 3'h7;
  localparam logic [1:0]       EL_NONE   = 2'h0;
  localparam logic [1:0]       EL_TOGGLE = 2'h1;
  localparam logic [1:0]       EL_LOW    = 2'h2;
  localparam logic [1:0]       EL_HIGH   = 2'h3;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] MOD_RESET = 16'hFFFF;

  typedef enum logic [2:0] {
    TMR_MODE_PRESET  = 3'b001,
    TMR_MODE_CAPTURE = 3'b010,
    TMR_MODE_COMPARE = 3'b100
  } tmr_mode_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tmr_apb_req_type;

  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } tmr_apb_rsp_type;

  typedef struct packed {
    logic             flag;
    logic             arm;
    logic             ie;
    logic             bufsel;
    logic             unbuf;
    logic [1:0]       els;
    logic             tov;
    logic             fmax;
    logic             max_act;
    logic             lvl_out;
    logic             pin_prev;
    logic             wlock;
    logic             rlock;
    logic [CNT_W-1:0] val;
  } tmr_chan_type;

  typedef struct packed {
    tmr_apb_rsp_type        rsp;
    logic                   ovf_flag;
    logic                   ovf_arm;
    logic                   ovf_ie;
    logic                   halt;
    logic [2:0]             ps;
    logic [PRE_W-1:0]       pre;
    logic [CNT_W-1:0]       cnt;
    logic [7:0]             cnt_buf;
    logic                   cnt_lat;
    logic [CNT_W-1:0]       mod;
    logic                   mod_lock;
    logic                   sel;
    logic                   last_wr;
    tmr_chan_type [CH_N-1:0] ch;
    logic                   ovf_irq;
    logic [CH_N-1:0]        ch_irq;
    logic [CH_N-1:0]        pin_out;
    logic [CH_N-1:0]        pin_oe_n;
  } tmr_state_type;

  typedef struct packed {
    logic [CH_N-1:0] s1;
    logic [CH_N-1:0] s2;
    logic [CH_N-1:0] s3;
    logic [CH_N-1:0] lvl;
  } tmr_sync_type;

  localparam tmr_state_type ST_RESET = '{halt: 1'b1, mod: MOD_RESET, pin_out: 2'h3,
                                          pin_oe_n: 2'h3, default: '0};

endpackage : tmr_pkg

//--- verification/dual_channel_capture_compare_timer_tb.sv
// self-checking bench for the capture/compare timer unit
`timescale 1ns/1ps
`default_nettype none
module dual_channel_capture_compare_timer_tb;
  import tmr_pkg::*;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  tmr_apb_req_type req = '0;
  tmr_apb_rsp_type rsp;
  logic [1:0]      ext = 2'h0;
  logic [1:0]      pin, pout, poe_n, cirq;
  logic            oirq, err;
  logic [31:0]     rd;
  logic [15:0]     cnt;
  int              fail_count = 0;
  int              n_tests = 0;
  int              cyc = 0;
  int              seed = 15552;
  int              m, v;

  always #5 clk = ~clk;

  tmr_capture_compare dut_u (.i_sys_clk(clk), .i_resetn(rstn), .i_apb(req),
    .o_apb(rsp), .i_ch_pin(pin), .o_ch_pin_out(pout), .o_ch_pin_oe_n(poe_n),
    .o_ovf_irq(oirq), .o_ch_irq(cirq));
  tmr_pin_model pm_u (.i_ext_lvl(ext), .i_drv(pout), .i_oe_n(poe_n), .o_pin(pin));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  function automatic int exp_cnt(int k);
    return (k == 7) ? 0 : 64 >> k;
  endfunction : exp_cnt

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(0, OFS_SC, 0); chk(rd, 32'h20);
    apb(0, OFS_MODH, 0); chk(rd, 32'hFF);
    apb(0, OFS_CS[0], 0); chk(rd, 32'h0);
    apb(0, 8'h3C, 0); chk({31'h0, err}, 32'h1);
    // modulo high alone must keep the overflow flag quiet
    m = 3 + ($unsigned($random(seed)) % 8);
    apb(1, OFS_SC, 8'h30);
    apb(1, OFS_MODH, 8'h00);
    apb(1, OFS_SC, 8'h40);
    // long enough for the counter to pass the half-written modulo
    repeat (300) @(posedge clk);
    chk({31'h0, oirq}, 32'h0);
    apb(1, OFS_SC, 8'h70);
    apb(1, OFS_MODL, m[7:0]);
    apb(1, OFS_SC, 8'h40);
    repeat (40) @(posedge clk);
    chk({31'h0, oirq}, 32'h1);
    apb(0, OFS_SC, 0); chk(rd & 32'h80, 32'h80);
    apb(1, OFS_SC, 8'hE0);
    apb(0, OFS_SC, 0); chk(rd, 32'hE0);
    apb(1, OFS_SC, 8'h60);
    apb(0, OFS_SC, 0); chk(rd, 32'h60);
    chk({31'h0, oirq}, 32'h0);
    apb(0, OFS_CNTH, 0); chk(rd, 32'h0);
    apb(0, OFS_CNTL, 0); chk({31'h0, rd <= m}, 32'h1);
    // prescaler: 64 bus clocks of counting per code, two counts of slack each way
    apb(1, OFS_MODH, 8'hFF);
    apb(1, OFS_MODL, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      apb(1, OFS_SC, 8'h30);
      apb(0, OFS_CNTL, 0); chk(rd, 32'h0);
      apb(1, OFS_SC, k[7:0]);
      repeat (61) @(posedge clk);
      apb(1, OFS_SC, 8'h20 | k[7:0]);
      apb(0, OFS_CNTH, 0); cnt[15:8] = rd[7:0];
      apb(0, OFS_CNTL, 0); cnt[7:0] = rd[7:0];
      chk({31'h0, cnt + 2 >= exp_cnt(k) && cnt <= exp_cnt(k) + 2}, 32'h1);
    end
    apb(0, OFS_MODL, 0); chk(rd, 32'hFF);
    // capture edges; pin has sat low for many clocks before enabling
    for (int c = 1; c < 4; c++) begin
      apb(1, OFS_SC, 8'h30);
      apb(1, OFS_CS[0], 8'(c << 2));
      apb(1, OFS_SC, 8'h00);
      ext[0] <= 1'b1;
      repeat (10) @(posedge clk);
      apb(0, OFS_CS[0], 0); chk({31'h0, rd[7]}, {31'h0, c[0]});
      apb(1, OFS_CS[0], 8'(c << 2));
      ext[0] <= 1'b0;
      repeat (10) @(posedge clk);
      apb(0, OFS_CS[0], 0); chk({31'h0, rd[7]}, {31'h0, c[1]});
    end
    apb(1, OFS_SC, 8'h30);
    apb(1, OFS_CS[0], 8'h10);
    repeat (3) @(posedge clk);
    chk({30'h0, poe_n}, 32'h3);
    chk({30'h0, pout}, 32'h2);
    apb(1, OFS_MODH, 8'h00);
    apb(1, OFS_MODL, 8'h40);
    // compare actions toggle, low, high; level runs 0 -> 1 -> 0 -> 1
    for (int e = 1; e < 4; e++) begin
      v = 16 + ($unsigned($random(seed)) % 32);
      apb(1, OFS_SC, 8'h30);
      apb(1, OFS_CS[0], 8'(8'h50 | e << 2));
      apb(1, OFS_VH[0], 8'h00);
      apb(1, OFS_VL[0], v[7:0]);
      apb(1, OFS_SC, 8'h00);
      repeat (v + 8) @(posedge clk);
      apb(1, OFS_SC, 8'h20);
      repeat (2) @(posedge clk);
      chk({30'h0, poe_n}, 32'h2);
      chk({31'h0, pout[0]}, {31'h0, e != 2});
      chk({30'h0, cirq}, 32'h1);
      apb(0, OFS_CS[0], 0); chk({31'h0, rd[7]}, 32'h1);
    end
    // zero duty, then forced full duty; both must outlast two periods
    apb(1, OFS_SC, 8'h30);
    apb(1, OFS_CS[0], 8'h18);
    apb(1, OFS_SC, 8'h00);
    repeat (150) @(posedge clk);
    chk({31'h0, pout[0]}, 32'h0);
    apb(1, OFS_CS[0], 8'h1B);
    repeat (150) @(posedge clk);
    chk({31'h0, pout[0]}, 32'h1);
    apb(1, OFS_SC, 8'h30);
    apb(0, OFS_CS[0], 0); chk({31'h0, rd[7]}, 32'h1);
    apb(1, OFS_CS[0], 8'h28);
    apb(1, OFS_CS[1], 8'hFF);
    apb(0, OFS_CS[1], 0); chk(rd, 32'h0);
    apb(0, OFS_CS[0], 0); chk(rd, 32'h28);
    chk({31'h0, poe_n[1]}, 32'h1);
    tally_and_finish();
  end
endmodule : dual_channel_capture_compare_timer_tb
`default_nettype wire

//--- verification/tmr_pin_model.sv
// channel pin model: the port side level unless the block drives the pin
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input  wire logic [1:0] i_ext_lvl,
  input  wire logic [1:0] i_drv,
  input  wire logic [1:0] i_oe_n,
  output var  logic [1:0] o_pin
);
  // released pin follows the port side, never the last driven level
  always_comb o_pin = (~i_oe_n & i_drv) | (i_oe_n & i_ext_lvl);
endmodule : tmr_pin_model
`default_nettype wire
